// ==== hdl/mtr_pkg.sv ====
package mtr_pkg;
    // Bus and data widths
    localparam int ADDR_W = 24;          // Eight octal digits
    localparam int DATA_W = 16;
    localparam int REG_AW = 5;
    // Register byte offsets
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_FIRST  = 5'h04;
    localparam logic [4:0] REG_LAST   = 5'h08;
    localparam logic [4:0] REG_AREA   = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_FADDR  = 5'h14;
    localparam logic [4:0] REG_EXP    = 5'h18;
    localparam logic [4:0] REG_ACT    = 5'h1c;
    // Control fields
    localparam int CTRL_GO  = 0;         // Write 1 to start, self-clearing
    localparam int CTRL_SEL = 1;         // 0 control memory, 1 data memory
    localparam logic CTRL_SEL_RST = 1'b0;
    // Status word fields; the result word has no busy bit, so each of its fields sits one bit lower
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_DIAG = 2;
    localparam int ST_DATA = 3;
    localparam int ST_SUM  = 4;          // Three bits: parity, nxm, control_memory_bus
    // Alignment masks for the two memories
    localparam logic [5:0] CTL_MASK = 6'h03;
    localparam logic [5:0] DAT_MASK = 6'h3f;
    // Address step of one 16-bit word, result word offset in the area
    localparam logic [23:0] WORD_STEP  = 24'h000002;
    localparam logic [23:0] RESULT_OFS = 24'h000004;
    // Pattern sequence: zero, grow to all ones, shrink to zero
    localparam logic [5:0] PAT_LAST = 6'h20;
    localparam logic [5:0] PAT_HALF = 6'h10;
    // No-acknowledge timeout
    localparam int CLK_PERIOD_NS = 10;
    localparam int NXM_TIME_NS   = 1000;
    localparam int NXM_CYC       = NXM_TIME_NS / CLK_PERIOD_NS;
    // Engine states, Gray coded along the normal path
    typedef enum logic [3:0] {
        S_IDLE = 4'h0, S_DIAG = 4'h1, S_PTR_RD = 4'h3, S_PTR_WR = 4'h2,
        S_FILL = 4'h6, S_CHECK = 4'h7, S_PAT_WR = 4'h5, S_VERIFY = 4'h4,
        S_REPORT = 4'hc, S_DONE = 4'hd
    } mtr_state_e;

    // Test pattern for a step of the sequence
    function automatic logic [15:0] mtr_pattern(input logic [5:0] idx);
        if (idx <= PAT_HALF)
            mtr_pattern = ~(16'hffff << idx);
        else
            mtr_pattern = 16'hffff >> (idx - PAT_HALF);
    endfunction : mtr_pattern

    // Force the unit bits of an address to zero or one
    function automatic logic [23:0] mtr_align(input logic [23:0] a,
                                              input logic sel,
                                              input logic up);
        logic [23:0] m;
        m = {18'h0, sel ? DAT_MASK : CTL_MASK};
        mtr_align = up ? (a | m) : (a & ~m);
    endfunction : mtr_align
endpackage : mtr_pkg

// ==== hdl/mtr_memory_test_requestor.sv ====
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module mtr_memory_test_requestor #(
    parameter int NXM_CYC = mtr_pkg::NXM_CYC
) (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic [mtr_pkg::REG_AW-1:0] reg_addr,
    input  wire logic [31:0]               reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [31:0]               reg_rdata,
    output logic                           mem_req,
    output logic                           mem_we,
    output logic                           mem_space,
    output logic      [mtr_pkg::ADDR_W-1:0] mem_addr,
    output logic      [mtr_pkg::DATA_W-1:0] mem_wdata,
    input  wire logic                      mem_ack,
    input  wire logic [mtr_pkg::DATA_W-1:0] mem_rdata,
    input  wire logic                      mem_parity_err,
    input  wire logic                      mem_control_memory_bus_err
);
    ////////////////////////////////////////////////////////////////////
    mtr_pkg::mtr_state_e state;          // Engine state
    logic        mem_sel;                // 0 control, 1 data memory
    logic [23:0] first_addr;             // Raw first address
    logic [23:0] last_addr;              // Raw last address
    logic [23:0] area_addr;              // Shared control area base
    logic [23:0] start_addr;             // Aligned copy used by the run
    logic [23:0] end_addr;               // Aligned copy used by the run
    logic [23:0] cur_addr;               // Location under test
    logic [5:0]  pidx;                   // Pattern step, also diag index
    logic [15:0] ptr_word;               // Pointer word read from area
    logic [7:0]  nxm_cnt;                // Wait for acknowledge
    logic        busy;
    logic        done;
    logic        diag_fail;
    logic        data_err;
    logic [2:0]  err_sum;                // Parity, nxm, control_memory_bus
    logic [23:0] failing_address;
    logic [15:0] expected_pattern;
    logic [15:0] actual_pattern;
    logic        go;                     // Start request from software
    logic        go_sel;                 // Select carried by the start write
    logic        acc_state;              // State that owns a bus access
    logic        acc_ack;
    logic        acc_nxm;
    logic        acc_bad;
    logic        acc_ok;
    logic [15:0] exp_now;                // Value a read should return
    logic        mismatch;
    logic        diag_ok;
    logic [15:0] pat_now;                // Pattern of the current step
    logic [15:0] pat_next;               // Pattern of the step after
    logic        at_end;
    logic        next_we;
    logic [23:0] next_addr;
    logic [15:0] next_wdata;

    ////////////////////////////////////////////////////////////////////
    // Decode of the current access and its outcome
    assign go = reg_wr && reg_addr == mtr_pkg::REG_CTRL
             && reg_wdata[mtr_pkg::CTRL_GO] && !busy;
    // The select lands in mem_sel on the same edge as the start, so the
    // alignment takes the select bit straight from the start write
    assign go_sel = reg_wdata[mtr_pkg::CTRL_SEL];
    assign acc_state = state inside {mtr_pkg::S_PTR_RD, mtr_pkg::S_PTR_WR,
        mtr_pkg::S_FILL, mtr_pkg::S_CHECK, mtr_pkg::S_PAT_WR,
        mtr_pkg::S_VERIFY, mtr_pkg::S_REPORT};
    assign acc_ack = mem_req && mem_ack;
    // Silence on the bus past the timeout means no module answered
    assign acc_nxm = mem_req && !mem_ack && nxm_cnt == 8'(NXM_CYC - 1);
    assign acc_bad = acc_ack && (mem_parity_err || mem_control_memory_bus_err);
    assign acc_ok  = acc_ack && !acc_bad;
    // Check step compares with the previous pattern, verify with this one
    assign exp_now = state == mtr_pkg::S_CHECK
                   ? mtr_pkg::mtr_pattern(pidx - 6'h1)
                   : mtr_pkg::mtr_pattern(pidx);
    assign mismatch = acc_ok && mem_rdata != exp_now
                   && (state == mtr_pkg::S_CHECK
                       || state == mtr_pkg::S_VERIFY);
    // Built-in check that each step adds or drops exactly one edge bit
    assign pat_now  = mtr_pkg::mtr_pattern(pidx);
    assign pat_next = mtr_pkg::mtr_pattern(pidx + 6'h1);
    assign diag_ok  = pat_next == (pidx < mtr_pkg::PAT_HALF
                                   ? {pat_now[14:0], 1'b1}
                                   : {1'b0, pat_now[15:1]});
    assign at_end = cur_addr >= end_addr - mtr_pkg::WORD_STEP + 24'h1;

    // Access attributes for the state about to launch
    always_comb begin
        next_we    = 1'b0;
        next_addr  = cur_addr;
        next_wdata = 16'h0;
        case (state)
            mtr_pkg::S_PTR_RD: next_addr = area_addr;
            mtr_pkg::S_PTR_WR: begin
                next_we    = 1'b1;
                next_addr  = area_addr;
                next_wdata = ~ptr_word;
            end
            mtr_pkg::S_FILL: begin
                next_we    = 1'b1;
                next_wdata = mtr_pkg::mtr_pattern(6'h0);
            end
            mtr_pkg::S_PAT_WR: begin
                next_we    = 1'b1;
                next_wdata = mtr_pkg::mtr_pattern(pidx);
            end
            mtr_pkg::S_REPORT: begin
                next_we    = 1'b1;
                next_addr  = area_addr + mtr_pkg::RESULT_OFS;
                next_wdata = {10'h0, err_sum, data_err,
                              diag_fail, 1'b1};
            end
            default: ;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Software-written settings
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_sel    <= mtr_pkg::CTRL_SEL_RST;
            first_addr <= 24'h0;
            last_addr  <= 24'h0;
            area_addr  <= 24'h0;
        end else if (reg_wr && !busy) begin
            // Settings are frozen while a run is in progress
            case (reg_addr)
                mtr_pkg::REG_CTRL:  mem_sel <= reg_wdata[mtr_pkg::CTRL_SEL];
                mtr_pkg::REG_FIRST: first_addr <= reg_wdata[23:0];
                mtr_pkg::REG_LAST:  last_addr  <= reg_wdata[23:0];
                mtr_pkg::REG_AREA:  area_addr  <= reg_wdata[23:0];
                default: ;
            endcase
        end
    end

    // Read port, data valid only in the cycle after the strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0;
        end else begin
            case (reg_addr)
                mtr_pkg::REG_CTRL:   reg_rdata <= {30'h0, mem_sel, 1'b0};
                mtr_pkg::REG_FIRST:  reg_rdata <= {8'h0, first_addr};
                mtr_pkg::REG_LAST:   reg_rdata <= {8'h0, last_addr};
                mtr_pkg::REG_AREA:   reg_rdata <= {8'h0, area_addr};
                mtr_pkg::REG_STATUS: reg_rdata <= {25'h0, err_sum,
                    data_err, diag_fail, done, busy};
                mtr_pkg::REG_FADDR:  reg_rdata <= {8'h0, failing_address};
                mtr_pkg::REG_EXP:    reg_rdata <= {16'h0, expected_pattern};
                mtr_pkg::REG_ACT:    reg_rdata <= {16'h0, actual_pattern};
                default:             reg_rdata <= 32'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Memory bus master: one access in flight, launched a cycle after
    // the previous one ends so each state sees its own attributes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_space <= 1'b0;
            mem_addr  <= 24'h0;
            mem_wdata <= 16'h0;
            nxm_cnt   <= 8'h0;
        end else if (mem_req) begin
            nxm_cnt <= nxm_cnt + 8'h1;
            if (mem_ack || acc_nxm)
                mem_req <= 1'b0;
        end else if (acc_state) begin
            mem_req   <= 1'b1;
            mem_we    <= next_we;
            // The control area always lives in control memory
            mem_space <= mem_sel && state != mtr_pkg::S_PTR_RD
                      && state != mtr_pkg::S_PTR_WR
                      && state != mtr_pkg::S_REPORT;
            mem_addr  <= next_addr;
            mem_wdata <= next_wdata;
            nxm_cnt   <= 8'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Test sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state      <= mtr_pkg::S_IDLE;
            pidx       <= 6'h0;
            cur_addr   <= 24'h0;
            start_addr <= 24'h0;
            end_addr   <= 24'h0;
            ptr_word   <= 16'h0;
        end else begin
            case (state)
                mtr_pkg::S_IDLE, mtr_pkg::S_DONE: if (go) begin
                    state      <= mtr_pkg::S_DIAG;
                    pidx       <= 6'h0;
                    start_addr <= mtr_pkg::mtr_align(first_addr,
                                                     go_sel, 1'b0);
                    end_addr   <= mtr_pkg::mtr_align(last_addr,
                                                     go_sel, 1'b1);
                end
                mtr_pkg::S_DIAG: begin
                    if (!diag_ok)
                        state <= mtr_pkg::S_DONE;
                    else if (pidx == mtr_pkg::PAT_LAST - 6'h1)
                        state <= mtr_pkg::S_PTR_RD;
                    pidx <= pidx + 6'h1;
                end
                mtr_pkg::S_PTR_RD: if (acc_ok) begin
                    ptr_word <= mem_rdata;
                    state    <= mtr_pkg::S_PTR_WR;
                end
                mtr_pkg::S_PTR_WR: if (acc_ok) begin
                    cur_addr <= start_addr;
                    pidx     <= 6'h1;
                    state    <= mtr_pkg::S_FILL;
                end
                mtr_pkg::S_FILL: if (acc_ok) begin
                    cur_addr <= at_end ? start_addr
                                       : cur_addr + mtr_pkg::WORD_STEP;
                    if (at_end)
                        state <= mtr_pkg::S_CHECK;
                end
                mtr_pkg::S_CHECK: if (acc_ok && !mismatch)
                    state <= mtr_pkg::S_PAT_WR;
                mtr_pkg::S_PAT_WR: if (acc_ok)
                    state <= mtr_pkg::S_VERIFY;
                mtr_pkg::S_VERIFY: if (acc_ok && !mismatch) begin
                    state    <= mtr_pkg::S_CHECK;
                    cur_addr <= cur_addr + mtr_pkg::WORD_STEP;
                    if (at_end) begin
                        cur_addr <= start_addr;
                        pidx     <= pidx + 6'h1;
                        if (pidx == mtr_pkg::PAT_LAST)
                            state <= mtr_pkg::S_REPORT;
                    end
                end
                mtr_pkg::S_REPORT: if (acc_ok || acc_bad || acc_nxm)
                    state <= mtr_pkg::S_DONE;
                default: state <= mtr_pkg::S_IDLE;
            endcase
            // Any failed access or compare abandons the run
            if ((acc_bad || acc_nxm || mismatch)
                && state != mtr_pkg::S_REPORT)
                state <= mtr_pkg::S_REPORT;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Run status and error capture; first error of a run is kept
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy             <= 1'b0;
            done             <= 1'b0;
            diag_fail        <= 1'b0;
            data_err         <= 1'b0;
            err_sum          <= 3'h0;
            failing_address  <= 24'h0;
            expected_pattern <= 16'h0;
            actual_pattern   <= 16'h0;
        end else if (go) begin
            busy      <= 1'b1;
            done      <= 1'b0;
            diag_fail <= 1'b0;
            data_err  <= 1'b0;
            err_sum   <= 3'h0;
        end else begin
            if (state == mtr_pkg::S_DIAG && !diag_ok) begin
                diag_fail <= 1'b1;
                busy      <= 1'b0;
                done      <= 1'b1;
            end
            if (state == mtr_pkg::S_REPORT
                && (acc_ok || acc_bad || acc_nxm)) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
            if ((acc_bad || acc_nxm || mismatch)
                && state != mtr_pkg::S_REPORT) begin
                failing_address  <= mem_addr;
                expected_pattern <= mem_we ? mem_wdata : exp_now;
                actual_pattern   <= mem_rdata;
                data_err         <= mismatch;
                err_sum <= {mem_parity_err && acc_ack,
                            acc_nxm, mem_control_memory_bus_err && acc_ack};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_first_align;
        busy |-> (mem_sel ? start_addr[5:0] == 6'h0
                          : start_addr[1:0] == 2'h0);
    endproperty
    a_first_align: assert property (p_first_align)
        else $error("first address not aligned");

    property p_last_align;
        busy |-> (mem_sel ? end_addr[5:0] == 6'h3f
                          : end_addr[1:0] == 2'h3);
    endproperty
    a_last_align: assert property (p_last_align)
        else $error("last address not aligned");

    property p_diag_first;
        $rose(state == mtr_pkg::S_PTR_RD) |-> $past(pidx) == 6'h1f;
    endproperty
    a_diag_first: assert property (p_diag_first)
        else $error("area access before diagnostics ended");

    property p_ptr_compl;
        (mem_req && state == mtr_pkg::S_PTR_WR) |-> mem_we
            && mem_wdata == ~ptr_word && mem_addr == area_addr;
    endproperty
    a_ptr_compl: assert property (p_ptr_compl)
        else $error("pointer word not complemented");

    property p_nxm;
        acc_nxm && state != mtr_pkg::S_REPORT |=>
            err_sum[1] && failing_address == $past(mem_addr);
    endproperty
    a_nxm: assert property (p_nxm)
        else $error("missing acknowledge not recorded");

    property p_verify;
        (state == mtr_pkg::S_PAT_WR && acc_ok) |=>
            state == mtr_pkg::S_VERIFY ##1 mem_req && !mem_we
            && mem_addr == $past(mem_addr, 2);
    endproperty
    a_verify: assert property (p_verify)
        else $error("write not read back");

    property p_report;
        mismatch |=> data_err && expected_pattern != actual_pattern
            && state == mtr_pkg::S_REPORT;
    endproperty
    a_report: assert property (p_report)
        else $error("compare error not reported");

    property p_done;
        (state == mtr_pkg::S_REPORT && acc_ok) |=>
            done && !busy && state == mtr_pkg::S_DONE;
    endproperty
    a_done: assert property (p_done)
        else $error("completion not shown");
endmodule : mtr_memory_test_requestor

// ==== tb/mtr_mem_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Memory modules on the shared bus, with a hole and injectable faults
module mtr_mem_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic        mem_space,
    input  wire logic [23:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic             mem_ack,
    output logic      [15:0] mem_rdata,
    output logic             mem_parity_err,
    output logic             mem_control_memory_bus_err,
    input  wire logic [1:0]  dly,
    input  wire logic [23:0] top,
    input  wire logic [23:0] bad,
    input  wire logic [15:0] flip,
    input  wire logic [1:0]  fault
);
    logic [15:0] mem [0:511]; // Word store, both spaces
    logic [1:0]  cnt;         // Wait cycles spent on this access
    logic [8:0]  idx;         // Space bit picks the memory
    logic        hit;         // Read of the faulty word
    assign idx = {mem_space, mem_addr[8:1]};
    assign hit = (mem_addr == bad) && !mem_we;
    // Known contents so untouched words can be told apart
    initial for (int i = 0; i < 512; i++) mem[i] = 16'ha5c3 ^ 16'(i);
    // Answer after dly waits; the hole never acks
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0;
            mem_parity_err <= 1'b0;
            mem_control_memory_bus_err <= 1'b0;
            cnt <= 2'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_parity_err <= 1'b0;
            mem_control_memory_bus_err <= 1'b0;
            // Released data lines wander, never hold the last word
            mem_rdata <= ~mem_rdata;
            if (!mem_req || mem_ack) begin
                cnt <= 2'h0;
            end else if (mem_addr < top || mem_addr[8]) begin
                if (cnt != dly) begin
                    cnt <= cnt + 2'h1;
                end else begin
                    mem_ack <= 1'b1;
                    if (mem_we) mem[idx] <= mem_wdata;
                    mem_rdata <= mem[idx] ^ ((hit && fault == 2'h1)
                                             ? flip : 16'h0);
                    mem_parity_err <= hit && fault == 2'h2;
                    mem_control_memory_bus_err <= hit && fault == 2'h3;
                end
            end
        end
    end
endmodule : mtr_mem_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module testbench;
    logic        clk = 1'b0;
    logic        resetn, reg_wr, reg_rd, rd_d;
    logic [4:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, last;
    logic        mem_req, mem_we, mem_space, mem_ack, mem_parity_err;
    logic        mem_control_memory_bus_err;
    logic [23:0] mem_addr, top, bad;
    logic [15:0] mem_wdata, mem_rdata, flip;
    logic [1:0]  dly, fault;
    logic [31:0] exp_q[$], msk_q[$]; // Expected reads, oldest first
    int          err_total = 0, checks = 0, cyc = 0;
    // Short timeout keeps the hole test quick
    mtr_memory_test_requestor #(.NXM_CYC(8)) mtr_memory_test_requestor_i (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
        .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_parity_err(mem_parity_err), .mem_control_memory_bus_err(mem_control_memory_bus_err));
    mtr_mem_model mtr_mem_model_i (
        .clk(clk), .resetn(resetn), .mem_req(mem_req), .mem_we(mem_we),
        .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem_parity_err(mem_parity_err), .mem_control_memory_bus_err(mem_control_memory_bus_err),
        .dly(dly), .top(top), .bad(bad), .flip(flip), .fault(fault));
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (err_total == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One bus cycle; strobes set once per edge, never toggled twice
    task automatic bus(input logic w, input logic r, input logic [4:0] a,
                       input logic [31:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask : bus
    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, 1'b1, a, 32'h0);
    endtask : rd
    // Untouched word, tested run, untouched word: alignment bounds
    task automatic span(input int b, input int n);
        chk(32'(mtr_mem_model_i.mem[b-1]), 32'(16'ha5c3 ^ 16'(b-1)));
        for (int i = b; i < b + n; i++) chk(32'(mtr_mem_model_i.mem[i]), 0);
        chk(32'(mtr_mem_model_i.mem[b+n]), 32'(16'ha5c3 ^ 16'(b+n)));
    endtask : span
    // Set range and go, wait for idle, then read the outcome back
    task automatic run(input logic s, input logic [23:0] f, l,
                       input logic [31:0] st, fa, ac, rw,
                       input bit fe, de);
        dly <= 2'($urandom_range(0, 3)); // Prompt and slow memory
        bus(1'b1, 1'b0, mtr_pkg::REG_FIRST, {8'h0, f});
        bus(1'b1, 1'b0, mtr_pkg::REG_LAST, {8'h0, l});
        bus(1'b1, 1'b0, mtr_pkg::REG_AREA, 32'h100);
        bus(1'b1, 1'b0, mtr_pkg::REG_CTRL, {30'h0, s, 1'b1});
        bus(1'b0, 1'b0, 5'h0, 32'h0);
        repeat (40) @(posedge clk);
        do begin
            rd(mtr_pkg::REG_STATUS, 32'h0, 32'h0);
            bus(1'b0, 1'b0, 5'h0, 32'h0);
            @(posedge clk);
        end while (last[mtr_pkg::ST_BUSY] !== 1'b0);
        rd(mtr_pkg::REG_STATUS, st, '1);
        if (fe) rd(mtr_pkg::REG_FADDR, fa, '1);
        if (de) rd(mtr_pkg::REG_EXP, 32'h0, '1);
        if (de) rd(mtr_pkg::REG_ACT, ac, '1);
        bus(1'b0, 1'b0, 5'h0, 32'h0);
        repeat (2) @(posedge clk);
        chk(32'(mtr_mem_model_i.mem[9'h082]), rw);
    endtask : run
    ////////////////////////////////////////////////////////////////////
    // Oldest note meets the read data in the cycle it stands
    always @(posedge clk) begin
        if (rd_d) begin
            last <= reg_rdata;
            if (msk_q.pop_front() != 0) chk(reg_rdata, exp_q.pop_front());
            else void'(exp_q.pop_front());
        end
        rd_d <= reg_rd;
    end
    // Hang guard, well above the longest run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            err_total++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {dly, fault, bad, flip} = '0;
        top = 24'h200;
        void'($urandom(22497));
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(mtr_pkg::REG_CTRL, 32'h0, '1);
        rd(mtr_pkg::REG_STATUS, 32'h0, '1);
        rd(5'h1f, 32'h0, '1);
        // Clean control range, ragged ends
        run(1'b0, 24'h11, 24'h1c, 32'h2, 0, 0, 32'h1, 0, 0);
        // Pointer word starts as a543 and must read back inverted
        chk(32'(mtr_mem_model_i.mem[9'h080]), 32'h5abc);
        span(8, 8);
        // Clean data range
        run(1'b1, 24'h41, 24'h45, 32'h2, 0, 0, 32'h1, 0, 0);
        span(256 + 32, 32);
        rd(mtr_pkg::REG_CTRL, 32'h2, '1);
        // Corrupted read, parity and control bus faults
        fault <= 2'h1;
        bad <= 24'h14;
        flip <= 16'($urandom_range(1, 16'hffff));
        @(posedge clk);
        run(1'b0, 24'h10, 24'h1f, 32'h0a, 32'h14, 32'(flip), 32'h05, 1, 1);
        fault <= 2'h2;
        bad <= 24'h18;
        run(1'b0, 24'h10, 24'h1f, 32'h42, 32'h18, 0, 32'h21, 1, 0);
        fault <= 2'h3;
        run(1'b0, 24'h10, 24'h1f, 32'h12, 32'h18, 0, 32'h09, 1, 0);
        // Range runs past the end of memory
        fault <= 2'h0;
        top <= 24'h1a;
        run(1'b0, 24'h10, 24'h1f, 32'h22, 32'h1a, 0, 32'h11, 1, 0);
        stop_test();
    end
endmodule : testbench
